// File: src/smsg_gate.sv
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module smsg_gate (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic servo_ready_input,
   input wire logic ext_stop_terminal,
   input wire logic x_axis_stop_relay,
   input wire logic y_axis_stop_relay,
   input wire logic [smsg_pkg::CODE_W-1:0] instr_code,
   input wire logic [smsg_pkg::POS_W-1:0] present_pos,
   input wire logic decel_done,
   output logic pulse_enable,
   output logic decel_req,
   output logic error_reset,
   output logic jump_next,
   output logic jump_end,
   output logic aux_code_on,
   output logic [smsg_pkg::AUX_W-1:0] aux_code
);
   import smsg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   logic [31:0] ctrl;
   logic [POS_W-1:0] target;
   logic [POS_W-1:0] remain;
   logic [TMR_W-1:0] dwell_cnt;
   logic [7:0] wr_addr;
   logic wr_pend;
   logic bus_cmd_wr;
   logic [31:0] cmd_bits;
   logic [TMR_W-1:0] dwell_load;
   logic dwell_load_req;
   logic aux_load_req;
   logic [AUX_W-1:0] aux_load;

   // Slave never stalls and never answers with an error
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Capture the address phase of a write
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else if (hready) begin
         wr_pend <= hsel && htrans[1] && hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   // Write strobes decoded in the data phase, where hwdata stands
   assign bus_cmd_wr = wr_pend && (wr_addr == REG_CMD);
   assign cmd_bits = bus_cmd_wr ? hwdata : 32'h0000_0000;
   assign dwell_load_req = wr_pend && (wr_addr == REG_DWELL);
   assign dwell_load = hwdata[TMR_W-1:0];
   assign aux_load_req = wr_pend && (wr_addr == REG_AUX);
   assign aux_load = hwdata[AUX_W-1:0];

   // Configuration registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl <= CTRL_RESET;
         target <= '0;
      end else if (wr_pend) begin
         if (wr_addr == REG_CTRL) begin
            ctrl <= hwdata;
         end
         if (wr_addr == REG_TARGET) begin
            target <= hwdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stop source and decode
   logic stop_req;
   logic start_req;
   logic stop_d;
   logic stop_edge;
   logic [CTRL_MODE_W-1:0] mode;
   logic manual_mode;
   logic cpath;
   logic interp;
   logic intr_pos;
   smsg_dec_e next_dec;
   smsg_dec_e dec;
   smsg_state_e state;
   logic aux_wait;

   // All stop sources ORed; the software stop bit is only a one-cycle pulse,
   // so the edge detector below treats every source alike
   assign stop_req = ext_stop_terminal | x_axis_stop_relay | y_axis_stop_relay
                   | cmd_bits[CMD_STOP_BIT];
   assign start_req = cmd_bits[CMD_START_BIT];
   assign mode = ctrl[CTRL_MODE_LSB +: CTRL_MODE_W];
   assign manual_mode = ctrl[CTRL_MANUAL_BIT];
   assign cpath = ctrl[CTRL_CPATH_BIT];
   assign interp = (instr_code == CODE_LIN) || (instr_code == CODE_CW)
                || (instr_code == CODE_CCW) || (instr_code == CODE_CENTER);
   assign intr_pos = (instr_code == CODE_INT1) || (instr_code == CODE_INT2);
   assign stop_edge = stop_req && !stop_d;

   // Stop is edge triggered so a held input acts once
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stop_d <= 1'b0;
      end else begin
         stop_d <= stop_req;
      end
   end

   // Decision from the mode sampled at the stop
   // Modes 5 and 6 fall back to the end jump while the continuous path
   // flag is set, as in modes 1 and 2
   always_comb begin
      next_dec = SMSG_DEC_NONE;
      case (mode)
         3'd1: begin
            next_dec = (interp || intr_pos) ? SMSG_DEC_END : SMSG_DEC_RESUME;
         end
         3'd2: begin
            next_dec = (interp || intr_pos) ? SMSG_DEC_END : SMSG_DEC_NEXT;
         end
         3'd3, 3'd7: begin
            next_dec = SMSG_DEC_END;
         end
         3'd5: begin
            if (intr_pos || (interp && cpath)) begin
               next_dec = SMSG_DEC_END;
            end else begin
               next_dec = SMSG_DEC_RESUME;
            end
         end
         3'd6: begin
            if (intr_pos || (interp && cpath)) begin
               next_dec = SMSG_DEC_END;
            end else begin
               next_dec = SMSG_DEC_NEXT;
            end
         end
         default: begin
            next_dec = SMSG_DEC_NONE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Motion and dwell sequencing
   logic [$clog2(DWELL_TICK_CYC)-1:0] tick_cnt;
   logic tick;
   logic act_stop;

   // Modes 0 and 4 never act in automatic mode
   assign act_stop = stop_edge && !manual_mode && (next_dec != SMSG_DEC_NONE);
   assign tick = (tick_cnt == $bits(tick_cnt)'(DWELL_TICK_CYC - 1));

   // Dwell time base; cleared outside DWELL, so a paused dwell restarts its current tick
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tick_cnt <= '0;
      end else if (state != SMSG_DWELL || tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end

   // Main sequencer; decision held until a start from HELD clears it
   // HELD keeps the dwell count, so a paused dwell picks up where it left off
   // Stops in DECEL or HELD are ignored: the first stop already decided
   // A dwell load is only taken in IDLE; a busy axis drops it
   // Manual mode never acts on a stop here, only as an error reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= SMSG_IDLE;
         dec <= SMSG_DEC_NONE;
         dwell_cnt <= '0;
      end else begin
         case (state)
            SMSG_IDLE: begin
               if (dwell_load_req) begin
                  dwell_cnt <= dwell_load;
                  state <= SMSG_DWELL;
               end else if (start_req) begin
                  state <= SMSG_RUN;
               end
            end
            SMSG_RUN: begin
               if (act_stop) begin
                  dec <= next_dec;
                  state <= SMSG_DECEL;
               end else if (present_pos == target) begin
                  state <= SMSG_IDLE;
               end
            end
            SMSG_DECEL: begin
               if (decel_done) begin
                  state <= SMSG_HELD;
               end
            end
            SMSG_DWELL: begin
               if (act_stop) begin
                  dec <= next_dec;
                  if (next_dec == SMSG_DEC_RESUME) begin
                     state <= SMSG_HELD;
                  end else begin
                     dwell_cnt <= '0;
                     state <= SMSG_IDLE;
                  end
               end else if (dwell_cnt == '0) begin
                  state <= SMSG_IDLE;
               end else if (tick) begin
                  dwell_cnt <= dwell_cnt - 1'b1;
               end
            end
            SMSG_HELD: begin
               if (start_req) begin
                  dec <= SMSG_DEC_NONE;
                  if (dec == SMSG_DEC_RESUME && dwell_cnt != '0) begin
                     state <= SMSG_DWELL;
                  end else if (dec == SMSG_DEC_RESUME) begin
                     state <= SMSG_RUN;
                  end else begin
                     state <= SMSG_IDLE;
                  end
               end
            end
            default: begin
               state <= SMSG_IDLE;
            end
         endcase
      end
   end

   // Remaining distance frozen at rest point
   // Limitation: counts one way only; a rest point past the target wraps
   always_ff @(posedge core_clk) begin
      if (rst) begin
         remain <= '0;
      end else if (state == SMSG_DECEL && decel_done) begin
         remain <= target - present_pos;
      end
   end

   // Jump pulses; dwell skip in mode 2 is immediate
   always_ff @(posedge core_clk) begin
      if (rst) begin
         jump_next <= 1'b0;
         jump_end <= 1'b0;
      end else begin
         jump_next <= act_stop && (state == SMSG_DWELL)
                      && (next_dec == SMSG_DEC_NEXT);
         jump_end <= act_stop && (state == SMSG_DWELL)
                     && (next_dec == SMSG_DEC_END);
      end
   end

   // Manual-mode stop in modes 0 and 4 clears errors
   always_ff @(posedge core_clk) begin
      if (rst) begin
         error_reset <= 1'b0;
      end else begin
         error_reset <= stop_edge && manual_mode
                        && ((mode == 3'd0) || (mode == 3'd4));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Auxiliary code; a drive in standby has aux_code_on set
   assign aux_wait = aux_code_on;

   // Stop never touches aux-on; only host off command clears it
   // The end code rewrite follows the load, so a stop in the same cycle
   // as a new code still leaves the end code standing
   always_ff @(posedge core_clk) begin
      if (rst) begin
         aux_code_on <= 1'b0;
         aux_code <= '0;
      end else begin
         if (aux_load_req) begin
            aux_code <= aux_load;
            aux_code_on <= 1'b1;
         end else if (cmd_bits[CMD_AUX_OFF_BIT]) begin
            aux_code_on <= 1'b0;
         end
         if (stop_edge && aux_wait && !manual_mode
             && ((mode == 3'd3) || (mode == 3'd7))) begin
            aux_code <= AUX_END_CODE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pulse gating
   // Registered gate: a ready drop is seen one cycle late, traded for a
   // glitch-free flop output towards the drive
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pulse_enable <= 1'b0;
         decel_req <= 1'b0;
      end else begin
         pulse_enable <= (state == SMSG_RUN) && (ctrl[CTRL_SRV_CHK_BIT]
                         || servo_ready_input);
         decel_req <= (state == SMSG_DECEL);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, registered in data phase
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            REG_CTRL: begin
               hrdata <= ctrl;
            end
            REG_TARGET: begin
               hrdata <= target;
            end
            REG_STATUS: begin
               hrdata <= {25'h0, dec, state, aux_code_on, pulse_enable};
            end
            REG_REMAIN: begin
               hrdata <= remain;
            end
            REG_DWELL: begin
               hrdata <= {16'h0000, dwell_cnt};
            end
            REG_AUX: begin
               hrdata <= {24'h000000, aux_code};
            end
            default: begin
               hrdata <= 32'h0000_0000;
            end
         endcase
      end
   end
endmodule

// File: src/smsg_pkg.sv
// Behaviour
// - Setting 0: pulses only while servo ready
// - Setting 1: pulses regardless of servo ready
// - Stop from terminal or either axis relay
// - Modes 0,4: stop ignored in automatic mode
// - Modes 0,4: manual stop acts as error reset
// - Mode 1: stop, restart resumes remaining distance
// - Modes 1,2: interpolation/interrupt stop jumps to end
// - Mode 2: stop, discard remainder, next step
// - Mode 2: stop during dwell skips at once
// - Modes 3,7: stop, discard remainder, jump end
// - Modes 3,7: aux standby stop sets end code
// - Mode 5: resume during plain interpolation too
// - Mode 6: skip during plain interpolation too
// - Codes 01,02,03,31 mean interpolation
// - Codes 71,72 mean interrupt positioning
// - Resume drives exactly rest-to-target distance
// - Modes 1,5: dwell pauses, resumes remaining time
// - Modes 2,3,6,7: dwell halted, remainder dropped
// - End code replacement keeps aux-on unchanged
// - Modes 1,2,5,6: aux-on unchanged by stop
package smsg_pkg;
   localparam int POS_W = 32;
   localparam int TMR_W = 16;
   localparam int AUX_W = 8;
   localparam int CODE_W = 8;

   // AHB register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TARGET = 8'h04;
   localparam logic [7:0] REG_CMD = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_REMAIN = 8'h10;
   localparam logic [7:0] REG_DWELL = 8'h14;
   localparam logic [7:0] REG_AUX = 8'h18;

   // CTRL fields
   localparam int CTRL_SRV_CHK_BIT = 0;
   localparam int CTRL_MANUAL_BIT = 1;
   localparam int CTRL_CPATH_BIT = 2;
   localparam int CTRL_MODE_LSB = 4;
   localparam int CTRL_MODE_W = 3;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // CMD write bits
   localparam int CMD_START_BIT = 0;
   localparam int CMD_STOP_BIT = 1;
   localparam int CMD_AUX_OFF_BIT = 2;

   // Instruction codes
   localparam logic [CODE_W-1:0] CODE_LIN = 8'h01;
   localparam logic [CODE_W-1:0] CODE_CW = 8'h02;
   localparam logic [CODE_W-1:0] CODE_CCW = 8'h03;
   localparam logic [CODE_W-1:0] CODE_DWELL = 8'h04;
   localparam logic [CODE_W-1:0] CODE_CENTER = 8'h31;
   localparam logic [CODE_W-1:0] CODE_INT1 = 8'h71;
   localparam logic [CODE_W-1:0] CODE_INT2 = 8'h72;
   localparam logic [AUX_W-1:0] AUX_END_CODE = 8'h02;

   // Dwell tick: 10 ms per count at 40 MHz
   localparam int CLK_HZ = 40_000_000;
   localparam int DWELL_TICK_MS = 10;
   localparam int DWELL_TICK_CYC = CLK_HZ / 1000 * DWELL_TICK_MS;

   typedef enum logic [2:0] {
      SMSG_IDLE = 3'b000,
      SMSG_RUN = 3'b001,
      SMSG_DECEL = 3'b011,
      SMSG_HELD = 3'b010,
      SMSG_DWELL = 3'b110
   } smsg_state_e;

   typedef enum logic [1:0] {
      SMSG_DEC_NONE = 2'b00,
      SMSG_DEC_RESUME = 2'b01,
      SMSG_DEC_NEXT = 2'b10,
      SMSG_DEC_END = 2'b11
   } smsg_dec_e;
endpackage

// File: testbench/smsg_gate_assertions.sv
`timescale 1ns/1ps
module smsg_chk
   import smsg_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic servo_ready_input,
   input wire logic decel_done,
   input wire logic pulse_enable,
   input wire logic decel_req,
   input wire logic error_reset,
   input wire logic jump_next,
   input wire logic jump_end,
   input wire logic aux_code_on,
   input wire logic [smsg_pkg::AUX_W-1:0] aux_code
);
   logic dp_v;
   logic dp_w;
   logic [7:0] dp_a;
   logic [31:0] ctrl_q;
   logic aux_w;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // Shadow of the bus data phase, so setting-dependent checks know CTRL
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dp_v <= 1'b0;
      end else if (hready) begin
         dp_v <= hsel && htrans[1];
         dp_w <= hwrite;
         dp_a <= haddr[7:0];
      end
   end
   // CTRL copy updated at the data phase edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
      end else if (hready && dp_v && dp_w && dp_a == REG_CTRL) begin
         ctrl_q <= hwdata;
      end
   end
   // Software writes that may legally touch the aux outputs
   assign aux_w = dp_v && dp_w && (dp_a == REG_AUX || dp_a == REG_CMD);
   ////////////////////////////////////////
   chk_gate_ready:
   assert property (pulse_enable && !ctrl_q[0] && !$past(ctrl_q[0]) |->
      $past(servo_ready_input)) else $error("pulses without servo ready");
   chk_bus_okay:
   assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
   chk_stop_quiet:
   assert property ($rose(decel_req) |-> !(ctrl_q[6:4] inside {3'd0, 3'd4}))
      else $error("stop acted in ignore mode");
   chk_err_manual:
   assert property (error_reset |-> $past(ctrl_q[1]) ##1 !error_reset)
      else $error("error reset outside manual or too long");
   chk_decel_hold:
   assert property (decel_req && !decel_done |=> decel_req)
      else $error("decel dropped before rest");
   chk_rest_nopulse:
   assert property ($past(decel_req) && decel_req |-> !pulse_enable)
      else $error("pulses during decel");
   chk_jump_once:
   assert property ((jump_next || jump_end) |-> !(jump_next && jump_end)
      ##1 !(jump_next || jump_end)) else $error("jump pulse malformed");
   chk_aux_end:
   assert property ($changed(aux_code) && !$past(aux_w) && !$past(rst) |->
      aux_code == AUX_END_CODE && $stable(aux_code_on)) else $error("aux code bad");
   cover property (error_reset);
   cover property (jump_next);
   cover property (jump_end);
   cover property ($rose(decel_req));
endmodule
bind smsg_gate smsg_chk chk_u (
   .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .servo_ready_input(servo_ready_input), .decel_done(decel_done),
   .pulse_enable(pulse_enable), .decel_req(decel_req), .error_reset(error_reset),
   .jump_next(jump_next), .jump_end(jump_end), .aux_code_on(aux_code_on),
   .aux_code(aux_code)
);

// File: testbench/smsg_servo_model.sv
`timescale 1ns/1ps
module smsg_servo_model #(parameter bit HAS_READY = 1'b1) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ready_in,
   input wire logic [3:0] lat,
   input wire logic pulse_enable,
   input wire logic decel_req,
   output logic servo_ready_input,
   output logic [smsg_pkg::POS_W-1:0] present_pos,
   output logic decel_done
);
   logic [3:0] cnt;
   // A drive without ready output holds the line asserted
   assign servo_ready_input = HAS_READY ? ready_in : 1'b1;
   assign decel_done = decel_req ? (cnt == lat) : !pulse_enable;
   // Axis keeps coasting while braking, so the rest point trails the stop
   always_ff @(posedge core_clk) begin
      if (rst) begin
         present_pos <= '0;
         cnt <= '0;
      end else begin
         if (pulse_enable || (decel_req && cnt != lat)) present_pos <= present_pos + 1;
         cnt <= !decel_req ? 4'h0 : (cnt == lat) ? cnt : cnt + 4'h1;
      end
   end
endmodule

// File: testbench/smsg_gate_bench.sv
`timescale 1ns/1ps
module smsg_gate_bench;
   import smsg_pkg::*;
   logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, ready_in = 1;
   logic ext_stop_terminal = 0, x_axis_stop_relay = 0, y_axis_stop_relay = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, present_pos, r, tgt;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] instr_code = 0, aux_code, a;
   logic [3:0] lat = 1;
   logic hready, hreadyout, hresp, servo_ready_input, decel_done, pulse_enable;
   logic decel_req, error_reset, jump_next, jump_end, aux_code_on;
   int n_errors = 0, tests_run = 0, n_er = 0, n_jn = 0, n_je = 0;
   logic [7:0] codes [7] = '{8'h00, CODE_LIN, CODE_CW, CODE_CCW, CODE_CENTER,
      CODE_INT1, CODE_INT2};
   assign hready = hreadyout;
   smsg_gate dut_u (
      .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .servo_ready_input(servo_ready_input),
      .ext_stop_terminal(ext_stop_terminal), .x_axis_stop_relay(x_axis_stop_relay),
      .y_axis_stop_relay(y_axis_stop_relay), .instr_code(instr_code),
      .present_pos(present_pos), .decel_done(decel_done), .pulse_enable(pulse_enable),
      .decel_req(decel_req), .error_reset(error_reset), .jump_next(jump_next),
      .jump_end(jump_end), .aux_code_on(aux_code_on), .aux_code(aux_code)
   );
   smsg_servo_model amp_u (
      .core_clk(core_clk), .rst(rst), .ready_in(ready_in), .lat(lat),
      .pulse_enable(pulse_enable), .decel_req(decel_req),
      .servo_ready_input(servo_ready_input), .present_pos(present_pos),
      .decel_done(decel_done)
   );
   initial forever #12.5 core_clk = ~core_clk;
   // Pulse outputs are counted so short pulses are never missed
   always @(posedge core_clk) begin
      n_er <= n_er + (error_reset === 1'b1);
      n_jn <= n_jn + (jump_next === 1'b1);
      n_je <= n_je + (jump_end === 1'b1);
   end
   ////////////////////////////////////////
   task complete_run;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // One single AHB transfer; hrdata is taken at the edge closing the data phase
   task ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1;
      haddr <= {24'h0, ad};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task rst_dut;
      rst <= 1;
      cyc(3);
      rst <= 0;
   endtask
   // Reference: decision kept after a stop in a given mode and instruction
   function automatic int exp_dec(int m, logic [7:0] c, bit cp);
      bit ip, ir;
      ip = c inside {CODE_LIN, CODE_CW, CODE_CCW, CODE_CENTER};
      ir = c inside {CODE_INT1, CODE_INT2};
      case (m)
         0, 4: return 0;
         3, 7: return 3;
         1, 2: return (ip || ir) ? 3 : m;
         default: return (ir || (ip && cp)) ? 3 : m - 4;
      endcase
   endfunction
   // Source 3 is the software stop bit; the others are the three pins
   task stop_pulse(input int s);
      if (s == 3) begin
         ahb(1, REG_CMD, 32'h0000_0002);
      end else begin
         {ext_stop_terminal, x_axis_stop_relay, y_axis_stop_relay} <= 3'h4 >> s;
         cyc(2);
         {ext_stop_terminal, x_axis_stop_relay, y_axis_stop_relay} <= 3'h0;
      end
      cyc(12);
   endtask
   task stop_test(input int m, input logic [7:0] c, input bit man, input bit cp);
      int d, e0;
      rst_dut();
      d = exp_dec(m, c, cp);
      instr_code <= c;
      lat <= $urandom_range(1, 8);
      tgt = $urandom_range(1000, 60000);
      ahb(1, REG_CTRL, (m << 4) | (cp << 2) | (man << 1) | 1);
      ahb(1, REG_TARGET, tgt);
      ahb(1, REG_CMD, 1);
      cyc(4);
      e0 = n_er;
      stop_pulse(m % 4);
      chk(n_er - e0, man);
      ahb(0, REG_STATUS, 0);
      chk(r[6:5], d);
      if (d == 1) begin
         ahb(0, REG_REMAIN, 0);
         chk(r, tgt - present_pos);
      end
      if (!man) begin
         ahb(1, REG_CMD, 1);
         cyc(3);
         chk(pulse_enable, d < 2);
      end
   endtask
   ////////////////////////////////////////
   initial begin
      int m, dw, j0, k0;
      void'($urandom(96));
      rst_dut();
      ahb(0, REG_CTRL, 0);
      chk(r, CTRL_RESET);
      ahb(1, 8'h40, 32'hFFFF_FFFF);
      ahb(0, 8'h40, 0);
      chk(r, 0);
      // Ready gate against both check settings
      for (int i = 0; i < 4; i++) begin
         rst_dut();
         ready_in <= i[0];
         ahb(1, REG_CTRL, i[1]);
         ahb(1, REG_TARGET, 32'h0000_1000);
         ahb(1, REG_CMD, 1);
         cyc(3);
         chk(pulse_enable, i[0] | i[1]);
      end
      ready_in <= 1;
      for (m = 0; m < 8; m++) foreach (codes[k]) stop_test(m, codes[k], 0, k % 2);
      stop_test(0, 0, 1, 0);
      stop_test(4, 0, 1, 0);
      // Stop during dwell with an aux code standing
      for (m = 1; m < 8; m++) begin
         if (m == 4) continue;
         rst_dut();
         instr_code <= CODE_DWELL;
         a = $urandom_range(8'h10, 8'hFF);
         dw = $urandom_range(2, 200);
         ahb(1, REG_CTRL, (m << 4) | 1);
         ahb(1, REG_AUX, a);
         ahb(1, REG_DWELL, dw);
         cyc(4);
         j0 = n_jn;
         k0 = n_je;
         stop_pulse(0);
         chk(n_jn - j0, m == 2 || m == 6);
         chk(n_je - k0, m == 3 || m == 7);
         chk(aux_code, (m == 3 || m == 7) ? AUX_END_CODE : a);
         chk(aux_code_on, 1);
         if (m == 1 || m == 5) begin
            ahb(0, REG_DWELL, 0);
            chk(r, dw);
         end
         ahb(1, REG_CMD, 4);
         cyc(2);
         chk(aux_code_on, 0);
         ahb(1, REG_CMD, 1);
      end
      complete_run();
   end
   // Hang guard well beyond the few thousand cycles the tests need
   initial begin
      #500000;
      n_errors++;
      complete_run();
   end
endmodule
